// ==== rtl/agta_target.sv ====
// AGP target end: arbiter, status codes, stop and request capture
`timescale 1ns/1ns
`default_nettype none
module agta_target (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_rst_n, // Shared bus reset, active low
  agta_link_if.target link, // Link to master
  input wire logic i_sb_enable, // Sideband port enabled
  input wire logic i_lp_read_pend, // Low priority read data ready
  input wire logic i_hp_read_pend, // High priority read data ready
  input wire logic i_lp_write_pend, // Low priority write data wanted
  input wire logic i_hp_write_pend, // High priority write data wanted
  input wire logic i_stop_req, // Ask master to stop
  output logic o_req_valid, // Enqueued request pulse
  output logic [15:0] o_req_word, // Enqueued request word
  output logic o_req_sideband, // Request came by sideband
  output logic o_served, // Data code issued pulse
  output logic [2:0] o_served_code, // Code that was issued
  output logic o_rbf_seen // Read buffer full level
);
  logic [4:0] sync_w;
  logic mode8x_w;
  logic req_w;
  logic rbf_w;
  logic pipe_w;
  logic strobe_w;
  logic strobe_d_reg;
  logic strobe_rise_w;
  logic [3:0] div_reg;
  logic agp_clk_reg;
  logic tick_rise_w;
  logic tick_fall_w;
  agta_pkg::agta_arb_state_t state_reg;
  logic grant_reg;
  logic [2:0] code_reg;
  logic [3:0] pick_w;
  logic byte_hi_reg;
  logic [7:0] low_byte_reg;
  logic [7:0] sb_byte_w;

  // Picks the next status code; bit 3 tells whether one is due
  function automatic logic [3:0] pick_code(
    input logic hpr,
    input logic hpw,
    input logic lpr,
    input logic lpw,
    input logic rbf,
    input logic req
  );
    logic [3:0] r;
    r = {1'b0, agta_pkg::STAT_GO};
    if (hpr)
    begin
      r = {1'b1, agta_pkg::STAT_HP_READ};
    end
    else if (hpw)
    begin
      r = {1'b1, agta_pkg::STAT_HP_WRITE};
    end
    else if (lpr & ~rbf)
    begin
      r = {1'b1, agta_pkg::STAT_LP_READ};
    end
    else if (lpw)
    begin
      r = {1'b1, agta_pkg::STAT_LP_WRITE};
    end
    else if (req)
    begin
      r = {1'b1, agta_pkg::STAT_GO};
    end
    return r;
  endfunction

  // Converts a pin level to its asserted sense for the active mode
  function automatic logic asserted(input logic pin, input logic m8x);
    return m8x ? pin : ~pin;
  endfunction

  agta_sync #(.W(5)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({link.mode_8x, link.bus_request_in, link.read_buffer_full,
              link.pipelined_request, link.sideband_strobe_first}),
    .o_sync(sync_w)
  );

  assign mode8x_w = sync_w[4];
  assign req_w = asserted(sync_w[3], mode8x_w);
  assign rbf_w = asserted(sync_w[2], mode8x_w);
  assign pipe_w = ~sync_w[1] & ~mode8x_w;
  assign strobe_w = sync_w[0];
  assign strobe_rise_w = strobe_w & ~strobe_d_reg;
  assign tick_rise_w = (div_reg == agta_pkg::AGP_HALF_LAST) & ~agp_clk_reg;
  assign tick_fall_w = (div_reg == agta_pkg::AGP_HALF_LAST) & agp_clk_reg;
  assign sb_byte_w = mode8x_w ? ~link.sideband_addr : link.sideband_addr;
  assign pick_w = pick_code(i_hp_read_pend, i_hp_write_pend, i_lp_read_pend,
                            i_lp_write_pend, rbf_w, req_w);

  // Link clock divider
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_reg <= agta_pkg::DIV_RST;
      agp_clk_reg <= 1'b0;
    end
    else if (div_reg == agta_pkg::AGP_HALF_LAST)
    begin
      div_reg <= agta_pkg::DIV_RST;
      agp_clk_reg <= ~agp_clk_reg;
    end
    else
    begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Arbiter decides on falling link edges; master samples on rising ones
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= agta_pkg::ARB_IDLE;
      grant_reg <= 1'b0;
      code_reg <= agta_pkg::STAT_RST;
      o_served <= 1'b0;
      o_served_code <= agta_pkg::STAT_RST;
    end
    else
    begin
      o_served <= 1'b0;
      case (state_reg)
        agta_pkg::ARB_IDLE:
        begin
          if (tick_fall_w & pick_w[3])
          begin
            grant_reg <= 1'b1;
            code_reg <= pick_w[2:0];
            state_reg <= agta_pkg::ARB_GRANT;
            o_served <= (pick_w[2:0] != agta_pkg::STAT_GO);
            o_served_code <= pick_w[2:0];
          end
        end
        agta_pkg::ARB_GRANT:
        begin
          if (tick_fall_w)
          begin
            grant_reg <= 1'b0;
            state_reg <= agta_pkg::ARB_IDLE;
          end
        end
        default:
        begin
          grant_reg <= 1'b0;
          state_reg <= agta_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // Pin drivers with mode polarity
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      link.agp_clk <= 1'b0;
      link.bus_grant_out <= 1'b1;
      link.agp_status_code <= agta_pkg::STAT_RST;
      link.target_stop <= 1'b1;
      o_rbf_seen <= 1'b0;
    end
    else
    begin
      link.agp_clk <= agp_clk_reg;
      link.bus_grant_out <= asserted(grant_reg, mode8x_w);
      link.agp_status_code <= code_reg;
      link.target_stop <= asserted(i_stop_req, mode8x_w);
      o_rbf_seen <= rbf_w;
    end
  end

  // Request capture from pipelined and sideband paths
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      strobe_d_reg <= 1'b0;
      byte_hi_reg <= 1'b0;
      low_byte_reg <= agta_pkg::BYTE_RST;
      o_req_valid <= 1'b0;
      o_req_word <= agta_pkg::WORD_RST;
      o_req_sideband <= 1'b0;
    end
    else
    begin
      strobe_d_reg <= strobe_w;
      o_req_valid <= 1'b0;
      if (!i_sb_enable)
      begin
        byte_hi_reg <= 1'b0;
      end
      else if (strobe_rise_w)
      begin
        if (!byte_hi_reg)
        begin
          low_byte_reg <= sb_byte_w;
          byte_hi_reg <= 1'b1;
        end
        else
        begin
          byte_hi_reg <= 1'b0;
          o_req_valid <= 1'b1;
          o_req_word <= {sb_byte_w, low_byte_reg};
          o_req_sideband <= 1'b1;
        end
      end
      if (tick_rise_w & pipe_w & ~(i_sb_enable & strobe_rise_w & byte_hi_reg))
      begin
        o_req_valid <= 1'b1;
        o_req_word <= link.ad_request;
        o_req_sideband <= 1'b0;
      end
    end
  end
  // Single reset input covers the whole port and no interrupt output exists
endmodule // agta_target
`default_nettype wire

// ==== rtl/agta_pkg.sv ====
// Shared constants and types for the AGP target arbiter and master ends
// Functional notes
// - Code 000 returns low priority read data
// - Code 001 returns high priority read data
// - Code 010 asks low priority write data
// - Codes 100, 101, 110 never issued
// - Code 111 lets master start a transaction
// - Master reads status only while granted
// - Target always drives the status lines
// - Read buffer full holds low priority reads
// - Undriven read buffer full reads deasserted
// - Request answered by grant
// - Sideband address ignored until enabled
// - Master times sideband bytes with strobes
// - Stop high in 8x, low in 4x
// - Enqueue method fixed at initialisation
// - 8x mode enqueues by sideband only
// - One shared reset for the whole port
// - No dedicated interrupt output
// - One pipelined request per rising clock
package agta_pkg;
  localparam logic [2:0] STAT_LP_READ = 3'h0;
  localparam logic [2:0] STAT_HP_READ = 3'h1;
  localparam logic [2:0] STAT_LP_WRITE = 3'h2;
  localparam logic [2:0] STAT_HP_WRITE = 3'h3;
  localparam logic [2:0] STAT_GO = 3'h7;
  localparam logic [2:0] STAT_RST = 3'h7;
  localparam int REF_CLK_PERIOD_NS = 4;
  localparam int AGP_CLK_PERIOD_NS = 80;
  localparam int AGP_HALF_CYCLES = AGP_CLK_PERIOD_NS / (2 * REF_CLK_PERIOD_NS);
  localparam logic [3:0] AGP_HALF_LAST = 4'(AGP_HALF_CYCLES - 1);
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [0:0] {ARB_IDLE, ARB_GRANT} agta_arb_state_t;
  typedef enum logic [2:0] {MST_IDLE, MST_REQ, MST_LAUNCH, MST_PIPE, MST_SB} agta_mst_state_t;
endpackage

// ==== rtl/agta_link_if.sv ====
// Link between the AGP target arbiter and the AGP master
`timescale 1ns/1ns
`default_nettype none
interface agta_link_if;
  logic agp_clk;
  logic mode_8x;
  logic bus_request_in;
  logic bus_grant_out;
  logic [2:0] agp_status_code;
  logic target_stop;
  logic pipelined_request;
  logic [15:0] ad_request;
  logic [7:0] sideband_addr;
  logic sideband_strobe_first;
  logic sideband_strobe_second;
  logic rbf_drive;
  logic rbf_oe_n;
  wire read_buffer_full;
  // Pull keeps the line deasserted when the master leaves it undriven
  assign read_buffer_full = rbf_oe_n ? ~mode_8x : rbf_drive;
  modport target (
    output agp_clk, bus_grant_out, agp_status_code, target_stop,
    input mode_8x, bus_request_in, pipelined_request, ad_request,
    input sideband_addr, sideband_strobe_first, sideband_strobe_second, read_buffer_full
  );
  modport master (
    input agp_clk, bus_grant_out, agp_status_code, target_stop,
    output mode_8x, bus_request_in, pipelined_request, ad_request,
    output sideband_addr, sideband_strobe_first, sideband_strobe_second, rbf_drive, rbf_oe_n
  );
endinterface
`default_nettype wire

// ==== rtl/agta_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module agta_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [W-1:0] i_async, // Foreign-domain input
  output logic [W-1:0] o_sync // Filtered synchronous level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      o_sync <= '0;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          o_sync[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // agta_sync
`default_nettype wire

// ==== rtl/agta_master.sv ====
// AGP master end: requests the bus and enqueues requests
`timescale 1ns/1ns
`default_nettype none
module agta_master (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_rst_n, // Async reset, active low
  agta_link_if.master link, // Link to target
  input wire logic i_mode_8x, // 8x transfer mode, caught after reset
  input wire logic i_use_sideband, // Sideband enqueue, caught after reset
  input wire logic i_want_bus, // Request word offered
  input wire logic [15:0] i_req_word, // Request word
  input wire logic i_rbf, // Read buffer full
  output logic o_req_ready, // Request word may be offered
  output logic o_status_valid, // Status sampled while granted
  output logic [2:0] o_status_code, // Sampled status code
  output logic o_stop_seen // Target asks to stop
);
  logic cfg_done_reg;
  logic mode8x_reg;
  logic sb_mode_reg;
  logic [5:0] sync_w;
  logic clk_d_reg;
  logic rise_w;
  logic fall_w;
  logic grant_w;
  agta_pkg::agta_mst_state_t state_reg;
  logic [15:0] word_reg;
  logic byte_idx_reg;

  agta_sync #(.W(6)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({link.agp_clk, link.bus_grant_out, link.agp_status_code, link.target_stop}),
    .o_sync(sync_w)
  );

  assign rise_w = sync_w[5] & ~clk_d_reg;
  assign fall_w = ~sync_w[5] & clk_d_reg;
  assign grant_w = sync_w[4] ~^ mode8x_reg;

  // Enqueue method caught once after reset release
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_done_reg <= 1'b0;
      mode8x_reg <= 1'b0;
      sb_mode_reg <= 1'b0;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      mode8x_reg <= i_mode_8x;
      sb_mode_reg <= i_use_sideband | i_mode_8x;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_d_reg <= 1'b0;
      o_status_valid <= 1'b0;
      o_status_code <= agta_pkg::STAT_RST;
      o_stop_seen <= 1'b0;
      link.mode_8x <= 1'b0;
      link.rbf_drive <= 1'b0;
      link.rbf_oe_n <= 1'b1;
    end
    else
    begin
      clk_d_reg <= sync_w[5];
      o_status_valid <= rise_w & grant_w;
      if (rise_w & grant_w)
      begin
        o_status_code <= sync_w[3:1];
      end
      o_stop_seen <= sync_w[0] ~^ mode8x_reg;
      link.mode_8x <= mode8x_reg;
      link.rbf_drive <= mode8x_reg;
      link.rbf_oe_n <= ~(i_rbf & cfg_done_reg);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= agta_pkg::MST_IDLE;
      word_reg <= agta_pkg::WORD_RST;
      byte_idx_reg <= 1'b0;
      o_req_ready <= 1'b0;
      link.bus_request_in <= 1'b1;
      link.pipelined_request <= 1'b1;
      link.ad_request <= agta_pkg::WORD_RST;
      link.sideband_addr <= 8'hff;
      link.sideband_strobe_first <= 1'b0;
      link.sideband_strobe_second <= 1'b1;
    end
    else
    begin
      o_req_ready <= cfg_done_reg & (state_reg == agta_pkg::MST_IDLE) & ~(o_req_ready & i_want_bus);
      if (rise_w & mode8x_reg)
      begin
        link.sideband_strobe_second <= 1'b0;
      end
      case (state_reg)
        agta_pkg::MST_IDLE:
        begin
          link.bus_request_in <= mode8x_reg ? 1'b0 : 1'b1;
          link.pipelined_request <= 1'b1;
          if (o_req_ready & i_want_bus)
          begin
            word_reg <= i_req_word;
            state_reg <= agta_pkg::MST_REQ;
          end
        end
        agta_pkg::MST_REQ:
        begin
          link.bus_request_in <= mode8x_reg ? 1'b1 : 1'b0;
          if (rise_w & grant_w & (sync_w[3:1] == agta_pkg::STAT_GO))
          begin
            state_reg <= agta_pkg::MST_LAUNCH;
          end
        end
        agta_pkg::MST_LAUNCH:
        begin
          if (fall_w)
          begin
            link.bus_request_in <= mode8x_reg ? 1'b0 : 1'b1;
            byte_idx_reg <= 1'b0;
            if (sb_mode_reg)
            begin
              link.sideband_addr <= mode8x_reg ? ~word_reg[7:0] : word_reg[7:0];
              state_reg <= agta_pkg::MST_SB;
            end
            else
            begin
              link.pipelined_request <= 1'b0;
              link.ad_request <= word_reg;
              state_reg <= agta_pkg::MST_PIPE;
            end
          end
        end
        agta_pkg::MST_PIPE:
        begin
          if (fall_w)
          begin
            link.pipelined_request <= 1'b1;
            state_reg <= agta_pkg::MST_IDLE;
          end
        end
        agta_pkg::MST_SB:
        begin
          if (rise_w & ~link.sideband_strobe_first)
          begin
            link.sideband_strobe_first <= 1'b1;
            link.sideband_strobe_second <= 1'b0;
          end
          else if (fall_w & link.sideband_strobe_first)
          begin
            link.sideband_strobe_first <= 1'b0;
            link.sideband_strobe_second <= 1'b1;
            if (!byte_idx_reg)
            begin
              byte_idx_reg <= 1'b1;
              link.sideband_addr <= mode8x_reg ? ~word_reg[15:8] : word_reg[15:8];
            end
            else
            begin
              state_reg <= agta_pkg::MST_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= agta_pkg::MST_IDLE;
        end
      endcase
    end
  end
endmodule // agta_master
`default_nettype wire

// ==== bench/agta_link_properties.sv ====
// Interface checks for the link between target and master ends
`timescale 1ns/1ns
`default_nettype none
module agta_link_properties (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic mode_8x, // Transfer mode
  input wire logic bus_request_in, // Request pin
  input wire logic bus_grant_out, // Grant pin
  input wire logic [2:0] agp_status_code, // Status lines
  input wire logic pipelined_request, // Pipe pin, active low
  input wire logic [15:0] ad_request, // Pipelined word
  input wire logic sideband_strobe_first, // First strobe
  input wire logic sideband_strobe_second, // Second strobe
  input wire logic read_buffer_full // Read buffer full pin
);
  logic [4:0] settle_reg;
  logic [5:0] gnt_len_reg;
  logic [5:0] gap_len_reg;
  logic settled;
  logic gnt_act;
  logic req_act;
  logic rbf_act;
  // Pin polarity follows mode only after it crosses the sync
  assign settled = settle_reg == 5'h10;
  assign gnt_act = mode_8x ? bus_grant_out : ~bus_grant_out;
  assign req_act = mode_8x ? bus_request_in : ~bus_request_in;
  assign rbf_act = mode_8x ? read_buffer_full : ~read_buffer_full;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n) settle_reg <= 5'h00;
    else if (!settled) settle_reg <= settle_reg + 5'h01;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n) gnt_len_reg <= 6'h00;
    else gnt_len_reg <= (settled && gnt_act) ? gnt_len_reg + 6'h01 : 6'h00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n) gap_len_reg <= 6'h3f;
    else if (!settled) gap_len_reg <= 6'h3f;
    else if (gnt_act) gap_len_reg <= 6'h00;
    else if (gap_len_reg != 6'h3f) gap_len_reg <= gap_len_reg + 6'h01;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence rbf_held_s;
    rbf_act [*8];
  endsequence
  sequence go_grant_s;
    settled && $rose(gnt_act) && agp_status_code == agta_pkg::STAT_GO;
  endsequence
  chk_no_reserved_code: assert property (!(agp_status_code inside {3'h4, 3'h5, 3'h6}))
    else $error("reserved status code driven");
  chk_grant_length: assert property (settled && $fell(gnt_act) |-> gnt_len_reg == 6'h14)
    else $error("grant did not stand one link period");
  chk_grant_gap: assert property (settled && $rose(gnt_act) |-> gap_len_reg >= 6'h14)
    else $error("grant reissued too soon");
  chk_code_stable: assert property (settled && gnt_act && $past(gnt_act) |-> $stable(agp_status_code))
    else $error("status changed during grant");
  chk_go_needs_req: assert property (go_grant_s |-> req_act && $past(req_act, 2))
    else $error("start grant without request");
  chk_go_launch: assert property (go_grant_s |-> ##[1:60] (!pipelined_request || sideband_strobe_first))
    else $error("master did not start after start grant");
  chk_rbf_hold_lp: assert property (rbf_held_s ##1 (settled && $rose(gnt_act) && rbf_act)
    |-> agp_status_code != agta_pkg::STAT_LP_READ)
    else $error("low priority read returned while buffer full");
  chk_pipe_8x_off: assert property (settled && mode_8x |-> pipelined_request)
    else $error("pipelined request used in 8x mode");
  chk_strobe_pair: assert property (settled && !mode_8x |-> sideband_strobe_second == !sideband_strobe_first)
    else $error("4x strobes not complementary");
  chk_pipe_word: assert property (!pipelined_request && !$past(pipelined_request) |-> $stable(ad_request))
    else $error("pipelined word changed within request");
endmodule // agta_link_properties
`default_nettype wire

// ==== bench/test_agp_target_arbiter_sideband.sv ====
// Self-checking bench joining the target and master ends
`timescale 1ns/1ns
`default_nettype none
module test_agp_target_arbiter_sideband;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sb_en = 1'b0;
  logic [3:0] pend = 4'h0;
  logic stop_req = 1'b0;
  logic mode_8x = 1'b0;
  logic use_sb = 1'b0;
  logic want = 1'b0;
  logic [15:0] word = 16'h0000;
  logic rbf = 1'b0;
  logic req_valid, req_sb, served, rbf_seen, req_ready, stat_valid, stop_seen;
  logic [15:0] req_word;
  logic [2:0] served_code, stat_code;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'h0389f228;
  agta_link_if lnk ();
  always #2 i_ref_clk = ~i_ref_clk;
  agta_target agta_target_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(lnk), .i_sb_enable(sb_en),
    .i_lp_read_pend(pend[0]), .i_hp_read_pend(pend[1]), .i_lp_write_pend(pend[2]), .i_hp_write_pend(pend[3]),
    .i_stop_req(stop_req), .o_req_valid(req_valid), .o_req_word(req_word), .o_req_sideband(req_sb),
    .o_served(served), .o_served_code(served_code), .o_rbf_seen(rbf_seen));
  agta_master agta_master_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(lnk), .i_mode_8x(mode_8x),
    .i_use_sideband(use_sb), .i_want_bus(want), .i_req_word(word), .i_rbf(rbf), .o_req_ready(req_ready),
    .o_status_valid(stat_valid), .o_status_code(stat_code), .o_stop_seen(stop_seen));
  agta_link_properties agta_link_properties_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .mode_8x(lnk.mode_8x), .bus_request_in(lnk.bus_request_in), .bus_grant_out(lnk.bus_grant_out),
    .agp_status_code(lnk.agp_status_code), .pipelined_request(lnk.pipelined_request),
    .ad_request(lnk.ad_request), .sideband_strobe_first(lnk.sideband_strobe_first),
    .sideband_strobe_second(lnk.sideband_strobe_second), .read_buffer_full(lnk.read_buffer_full));
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return req_valid;
      1: return served;
      2: return stat_valid;
      3: return stop_seen;
      default: return req_ready;
    endcase
  endfunction
  // Priority among pending data work
  function automatic logic [2:0] pick(input logic [3:0] p);
    if (p[1]) return agta_pkg::STAT_HP_READ;
    if (p[3]) return agta_pkg::STAT_HP_WRITE;
    if (p[0]) return agta_pkg::STAT_LP_READ;
    return agta_pkg::STAT_LP_WRITE;
  endfunction
  task automatic count(input int sel, input int lim, output int hits);
    hits = 0;
    repeat (lim)
    begin
      @(posedge i_ref_clk);
      #1;
      if (probe(sel) === 1'b1) hits++;
    end
  endtask
  // Running out of the bound ends the run
  task automatic await(input int sel, input int lim);
    for (int n = 0; n < lim; n++)
    begin
      @(posedge i_ref_clk);
      #1;
      if (probe(sel) === 1'b1) return;
    end
    $display("ERROR wait %0d expected 1 seen 0", sel);
    fail_count++;
    summarize();
  endtask
  task automatic do_reset(input int cfg);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    sb_en <= 1'b0;
    mode_8x <= (cfg == 2);
    use_sb <= (cfg == 1);
    repeat (6) @(posedge i_ref_clk);
    check("grant pin in reset", 16'h0001, 16'(lnk.bus_grant_out));
    check("status in reset", 16'(agta_pkg::STAT_RST), 16'(lnk.agp_status_code));
    i_rst_n <= 1'b1;
    repeat (30) @(posedge i_ref_clk);
    // Modes flipped after capture; master must keep the caught ones
    mode_8x <= (cfg != 2);
    use_sb <= (cfg != 1);
  endtask
  task automatic send(input logic [15:0] w, input logic seen, input logic sb);
    int hits;
    await(4, 300);
    @(posedge i_ref_clk);
    want <= 1'b1;
    word <= w;
    @(posedge i_ref_clk);
    want <= 1'b0;
    if (seen)
    begin
      await(0, 400);
      check("request word", w, req_word);
      check("request source", 16'(sb), 16'(req_sb));
    end
    else
    begin
      count(0, 400, hits);
      check("disabled sideband", 16'h0000, 16'(hits));
    end
  endtask
  initial
  begin
    logic [15:0] w;
    logic [3:0] left;
    logic [2:0] e;
    int hits;
    for (int cfg = 0; cfg < 3; cfg++)
    begin
      do_reset(cfg);
      if (cfg != 0) send(16'($random(seed)), 1'b0, 1'b1);
      @(posedge i_ref_clk);
      sb_en <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
        w = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : 16'($random(seed));
        send(w, 1'b1, cfg != 0);
      end
      @(posedge i_ref_clk);
      pend <= 4'hf;
      left = 4'hf;
      while (left != 4'h0)
      begin
        e = pick(left);
        await(1, 200);
        check("served code", 16'(e), 16'(served_code));
        left[e[1:0]] = 1'b0;
        @(posedge i_ref_clk);
        pend <= left;
        await(2, 60);
        check("master status", 16'(e), 16'(stat_code));
      end
      @(posedge i_ref_clk);
      rbf <= 1'b1;
      repeat (10) @(posedge i_ref_clk);
      #1;
      check("buffer full seen", 16'h0001, 16'(rbf_seen));
      @(posedge i_ref_clk);
      pend <= 4'h1;
      count(1, 120, hits);
      check("low read while full", 16'h0000, 16'(hits));
      @(posedge i_ref_clk);
      rbf <= 1'b0;
      await(1, 200);
      check("low read after full", 16'(agta_pkg::STAT_LP_READ), 16'(served_code));
      check("buffer full idle", 16'h0000, 16'(rbf_seen));
      @(posedge i_ref_clk);
      pend <= 4'h0;
      stop_req <= 1'b1;
      await(3, 20);
      check("stop pin", 16'(cfg == 2), 16'(lnk.target_stop));
      @(posedge i_ref_clk);
      stop_req <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      #1;
      check("stop pin idle", 16'(cfg != 2), 16'(lnk.target_stop));
      check("stop seen idle", 16'h0000, 16'(stop_seen));
      $display("Test mode %0d done", cfg);
    end
    summarize();
  end
endmodule // test_agp_target_arbiter_sideband
`default_nettype wire
